/* hw/iapc_ctrl.v */
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "iapc_defines.vh"
module iapc_ctrl #(
  parameter UNLOCK_CYC = `IAPC_UNLOCK_CYC
) (
  input wire core_clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire cpu_halt,
  output reg chip_reset_req,
  output reg [11:0] flash_addr,
  output reg [15:0] flash_wdata,
  output reg flash_wr_en,
  output reg flash_erase_en,
  input wire [15:0] flash_rdata
);
  localparam ST_IDLE = 2'd0;
  localparam ST_READ = 2'd1;
  localparam ST_PROG = 2'd2;
  localparam ST_CLR = 2'd3;

  reg [1:0] state_r;
  reg [7:0] cnt_r;
  reg [5:0] idx_r;
  reg wr_ph_r;
  reg [11:0] wa_r;
  reg mod_en_r;
  reg [2:0] op_r;
  reg unlock_r;
  reg prog_r;
  reg rperm_r;
  reg read_r;
  reg bufclr_r;
  reg [15:0] utmr_r;
  reg [7:0] rstkey_r;
  reg [7:0] rstcnt_r;
  reg [11:0] addr_r;
  reg [7:0] d0l_r;
  reg [7:0] d0h_r;
  reg [7:0] k1l_r, k1h_r, k2l_r, k2h_r, k3l_r, k3h_r;
  reg [15:0] buf_mem [0:31];
  reg [31:0] tag_r;
  reg [6:0] buf_page_r;
  reg [7:0] rd_byte;
  wire [7:0] wb = hwdata[7:0];
  integer i;

  wire wr_go = wr_ph_r;
  wire key_ok = k1l_r == `IAPC_KEY_L1 && k2l_r == `IAPC_KEY_L2 &&
    k3l_r == `IAPC_KEY_L3 && k1h_r == `IAPC_KEY_H1 &&
    k2h_r == `IAPC_KEY_H2 && k3h_r == `IAPC_KEY_H3;
  wire busy = state_r != ST_IDLE;
  wire [4:0] word_ix = idx_r[4:0];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Halting only for successfully launched operations.
  assign cpu_halt = state_r == ST_READ || state_r == ST_PROG;

  always @(posedge core_clk) begin
    if (reset) begin
      wr_ph_r <= 1'b0;
      wa_r <= 12'h000;
    end else if (hready) begin
      wr_ph_r <= hsel && htrans[1] && hwrite;
      wa_r <= haddr[11:0];
    end
  end

  always @* begin
    case (haddr[11:0])
      `IAPC_OFF_CTRL: rd_byte = {mod_en_r, op_r, unlock_r, prog_r,
                                 rperm_r, read_r};
      `IAPC_OFF_RSTKEY: rd_byte = rstkey_r;
      `IAPC_OFF_BUFCLR: rd_byte = {7'h00, bufclr_r};
      `IAPC_OFF_ADDRL: rd_byte = addr_r[7:0];
      `IAPC_OFF_ADDRH: rd_byte = {4'h0, addr_r[11:8]};
      `IAPC_OFF_D0L: rd_byte = d0l_r;
      `IAPC_OFF_D0H: rd_byte = d0h_r;
      `IAPC_OFF_K1L: rd_byte = k1l_r;
      `IAPC_OFF_K1H: rd_byte = k1h_r;
      `IAPC_OFF_K2L: rd_byte = k2l_r;
      `IAPC_OFF_K2H: rd_byte = k2h_r;
      `IAPC_OFF_K3L: rd_byte = k3l_r;
      `IAPC_OFF_K3H: rd_byte = k3h_r;
      default: rd_byte = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      hrdata <= 32'h00000000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= {24'h000000, rd_byte};
    end
  end

  always @(posedge core_clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      idx_r <= 6'h00;
      mod_en_r <= 1'b0;
      op_r <= 3'h0;
      unlock_r <= 1'b0;
      prog_r <= 1'b0;
      rperm_r <= 1'b0;
      read_r <= 1'b0;
      bufclr_r <= 1'b0;
      utmr_r <= 16'h0000;
      rstkey_r <= `IAPC_RST_BYTE;
      addr_r <= 12'h000;
      d0l_r <= `IAPC_RST_BYTE;
      d0h_r <= `IAPC_RST_BYTE;
      k1l_r <= `IAPC_RST_BYTE;
      k1h_r <= `IAPC_RST_BYTE;
      k2l_r <= `IAPC_RST_BYTE;
      k2h_r <= `IAPC_RST_BYTE;
      k3l_r <= `IAPC_RST_BYTE;
      k3h_r <= `IAPC_RST_BYTE;
      tag_r <= 32'h00000000;
      buf_page_r <= 7'h00;
      flash_addr <= 12'h000;
      flash_wdata <= 16'h0000;
      flash_wr_en <= 1'b0;
      flash_erase_en <= 1'b0;
    end else begin
      flash_wr_en <= 1'b0;
      flash_erase_en <= 1'b0;
      if (wr_go) begin
        case (wa_r)
          `IAPC_OFF_CTRL: begin
            // Clear only; a one written here never sets it.
            if (!wb[`IAPC_BIT_MODEN])
              mod_en_r <= 1'b0;
            op_r <= wb[6:4];
            // All three at once is illegal: bits 3:0 are ignored; op_r and the MODEN clear still apply.
            if (!(wb[`IAPC_BIT_PROG] && wb[`IAPC_BIT_RPERMIT] &&
                  wb[`IAPC_BIT_READ])) begin
              rperm_r <= wb[`IAPC_BIT_RPERMIT];
              if (wb[`IAPC_BIT_UNLOCK] && !unlock_r &&
                  wb[6:4] == `IAPC_OP_UNLOCK) begin
                unlock_r <= 1'b1;
                utmr_r <= UNLOCK_CYC[15:0];
              end
              if (wb[`IAPC_BIT_PROG] && !busy)
                prog_r <= 1'b1;
              if (wb[`IAPC_BIT_READ] && !busy)
                read_r <= 1'b1;
            end
          end
          `IAPC_OFF_RSTKEY: rstkey_r <= wb;
          `IAPC_OFF_BUFCLR: if (wb[`IAPC_BIT_BUFCLR] && !busy)
            bufclr_r <= 1'b1;
          `IAPC_OFF_ADDRL: addr_r[7:0] <= wb;
          `IAPC_OFF_ADDRH: addr_r[11:8] <= wb[3:0];
          `IAPC_OFF_D0L: d0l_r <= wb;
          `IAPC_OFF_D0H: begin
            d0h_r <= wb;
            // Load word, tag its slot, advance but pin at page end.
            buf_mem[addr_r[4:0]] <= {wb, d0l_r};
            tag_r[addr_r[4:0]] <= 1'b1;
            buf_page_r <= addr_r[11:5];
            if (addr_r[4:0] != `IAPC_PAGE_LAST)
              addr_r <= addr_r + 12'h001;
          end
          `IAPC_OFF_K1L: k1l_r <= wb;
          `IAPC_OFF_K1H: k1h_r <= wb;
          `IAPC_OFF_K2L: k2l_r <= wb;
          `IAPC_OFF_K2H: k2h_r <= wb;
          `IAPC_OFF_K3L: k3l_r <= wb;
          `IAPC_OFF_K3H: k3h_r <= wb;
          default: ;
        endcase
      end
      // Keys only count while the window is open.
      if (unlock_r) begin
        if (key_ok)
          mod_en_r <= 1'b1;
        if (utmr_r == 16'h0000)
          unlock_r <= 1'b0;
        else
          utmr_r <= utmr_r - 16'h0001;
      end
      case (state_r)
        ST_IDLE: begin
          if (read_r) begin
            // Without permit the request is dropped at once.
            if (rperm_r && op_r == `IAPC_OP_READ) begin
              state_r <= ST_READ;
              cnt_r <= `IAPC_READ_CYC;
              flash_addr <= addr_r;
            end else
              read_r <= 1'b0;
          end else if (prog_r) begin
            // No permission or wrong mode: nothing is touched.
            if (mod_en_r && (op_r == `IAPC_OP_WRITE ||
                op_r == `IAPC_OP_ERASE)) begin
              state_r <= ST_PROG;
              idx_r <= 6'h00;
              cnt_r <= `IAPC_PROG_CYC;
            end else
              prog_r <= 1'b0;
          end else if (bufclr_r) begin
            state_r <= ST_CLR;
          end
        end
        ST_READ: begin
          if (cnt_r == 8'h00) begin
            {d0h_r, d0l_r} <= flash_rdata;
            read_r <= 1'b0;
            state_r <= ST_IDLE;
          end else
            cnt_r <= cnt_r - 8'h01;
        end
        ST_PROG: begin
          // Revoked permission aborts the rest of the page.
          if (!mod_en_r || idx_r[5]) begin
            prog_r <= 1'b0;
            tag_r <= 32'h00000000;
            state_r <= ST_IDLE;
          end else if (cnt_r != 8'h00) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            if (tag_r[word_ix]) begin
              flash_addr <= {buf_page_r, word_ix};
              if (op_r == `IAPC_OP_ERASE) begin
                flash_wdata <= `IAPC_ERASED_WORD;
                flash_erase_en <= 1'b1;
              end else begin
                flash_wdata <= buf_mem[word_ix];
                flash_wr_en <= 1'b1;
              end
            end
            cnt_r <= `IAPC_PROG_CYC;
            idx_r <= idx_r + 6'h01;
          end
        end
        ST_CLR: begin
          for (i = 0; i < 32; i = i + 1)
            buf_mem[i] <= 16'h0000;
          tag_r <= 32'h00000000;
          bufclr_r <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // A held pulse so the chip reset tree sees a clean request.
  always @(posedge core_clk) begin
    if (reset) begin
      rstcnt_r <= 8'h00;
      chip_reset_req <= 1'b0;
    end else if (wr_go && wa_r == `IAPC_OFF_RSTKEY &&
                 hwdata[7:0] == `IAPC_RSTKEY_VAL) begin
      rstcnt_r <= `IAPC_RESET_CYC;
      chip_reset_req <= 1'b1;
    end else if (rstcnt_r != 8'h00) begin
      rstcnt_r <= rstcnt_r - 8'h01;
      chip_reset_req <= rstcnt_r != 8'h01;
    end
  end
endmodule

/* hw/iapc_defines.vh */
`ifndef IAPC_DEFINES_VH
`define IAPC_DEFINES_VH
`define IAPC_OFF_CTRL 12'h000
`define IAPC_OFF_RSTKEY 12'h004
`define IAPC_OFF_BUFCLR 12'h008
`define IAPC_OFF_ADDRL 12'h00c
`define IAPC_OFF_ADDRH 12'h010
`define IAPC_OFF_D0L 12'h014
`define IAPC_OFF_D0H 12'h018
`define IAPC_OFF_K1L 12'h01c
`define IAPC_OFF_K1H 12'h020
`define IAPC_OFF_K2L 12'h024
`define IAPC_OFF_K2H 12'h028
`define IAPC_OFF_K3L 12'h02c
`define IAPC_OFF_K3H 12'h030
`define IAPC_BIT_MODEN 7
`define IAPC_BIT_UNLOCK 3
`define IAPC_BIT_PROG 2
`define IAPC_BIT_RPERMIT 1
`define IAPC_BIT_READ 0
`define IAPC_BIT_BUFCLR 0
`define IAPC_OP_WRITE 3'h0
`define IAPC_OP_ERASE 3'h1
`define IAPC_OP_READ 3'h3
`define IAPC_OP_UNLOCK 3'h6
`define IAPC_KEY_L1 8'h00
`define IAPC_KEY_L2 8'h0d
`define IAPC_KEY_L3 8'hc3
`define IAPC_KEY_H1 8'h04
`define IAPC_KEY_H2 8'h09
`define IAPC_KEY_H3 8'h40
`define IAPC_RSTKEY_VAL 8'h55
`define IAPC_RST_BYTE 8'h00
`define IAPC_ERASED_WORD 16'h0000
`define IAPC_PAGE_LAST 5'h1f
`define IAPC_UNLOCK_CYC 16'd1000
`define IAPC_READ_CYC 8'd3
`define IAPC_PROG_CYC 8'd64
`define IAPC_RESET_CYC 8'd16
`endif

/* sim/iapc_flash_model.sv */
`timescale 1ns/10ps
module iapc_flash_model (
  input wire core_clk,
  input wire [11:0] flash_addr,
  input wire [15:0] flash_wdata,
  input wire flash_wr_en,
  input wire flash_erase_en,
  output wire [15:0] flash_rdata
);
  logic [15:0] mem [0:4095];
  // A non-blank start pattern makes a missed erase or write show up.
  initial begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 16'ha5a5 ^ i[15:0];
  end
  always @(posedge core_clk) begin
    if (flash_erase_en)
      mem[flash_addr] <= 16'h0000;
    else if (flash_wr_en)
      mem[flash_addr] <= flash_wdata;
  end
  assign flash_rdata = mem[flash_addr];
endmodule

/* sim/iapc_ctrl_checker.sv */
`timescale 1ns/10ps
module iapc_ctrl_checker #(
  parameter UNLOCK_CYC = 20
) (
  input wire core_clk,
  input wire reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire cpu_halt,
  input wire chip_reset_req,
  input wire [15:0] flash_wdata,
  input wire flash_wr_en,
  input wire flash_erase_en
);
  reg wr_ph_r;
  reg rd_ph_r;
  reg [11:0] ph_addr_r;
  reg [11:0] halt_cnt_r;
  // The slave is zero-wait, so every taken address phase has its data next.
  always @(posedge core_clk) begin
    if (reset) begin
      wr_ph_r <= 1'b0;
      rd_ph_r <= 1'b0;
      halt_cnt_r <= 12'h000;
    end else begin
      wr_ph_r <= hsel && htrans[1] && hwrite;
      rd_ph_r <= hsel && htrans[1] && !hwrite;
      ph_addr_r <= haddr[11:0];
      halt_cnt_r <= cpu_halt ? halt_cnt_r + 12'h001 : 12'h000;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence rst_key_s;
    wr_ph_r && ph_addr_r == 12'h004 && hwdata[7:0] == 8'h55;
  endsequence
  sequence rst_hold_s;
    chip_reset_req [*8];
  endsequence
  reset_req_a: assert property (rst_key_s |-> ##[1:3] chip_reset_req)
    else $error("chip reset not raised");
  reset_hold_a: assert property ($rose(chip_reset_req) |-> rst_hold_s)
    else $error("chip reset too short");
  halt_prog_a: assert property (
    flash_wr_en || flash_erase_en |-> cpu_halt)
    else $error("flash access without halt");
  wr_pulse_a: assert property (flash_wr_en |=> !flash_wr_en)
    else $error("write pulse too long");
  erase_zero_a: assert property (
    flash_erase_en |-> flash_wdata == 16'h0000)
    else $error("erase data not blank");
  flash_excl_a: assert property (!(flash_wr_en && flash_erase_en))
    else $error("erase and write together");
  halt_bound_a: assert property (halt_cnt_r < 12'h834)
    else $error("halt never released");
  bufclr_rd_a: assert property (rd_ph_r && ph_addr_r == 12'h008 |->
    hrdata[31:1] == 31'h0) else $error("buffer clear upper bits set");
endmodule
bind iapc_ctrl iapc_ctrl_checker #(.UNLOCK_CYC(UNLOCK_CYC))
  i_iapc_ctrl_checker (
  .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
  .cpu_halt(cpu_halt), .chip_reset_req(chip_reset_req),
  .flash_wdata(flash_wdata), .flash_wr_en(flash_wr_en),
  .flash_erase_en(flash_erase_en)
);

/* sim/iapc_ctrl_tb_top.sv */
`timescale 1ns/10ps
module iapc_ctrl_tb_top;
  localparam int UNL = 20;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire hready;
  wire [31:0] hrdata;
  wire cpu_halt;
  wire chip_reset_req;
  wire [11:0] flash_addr;
  wire [15:0] flash_wdata;
  wire flash_wr_en;
  wire flash_erase_en;
  wire [15:0] flash_rdata;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;
  logic rd_ph = 1'b0;
  logic [31:0] exp_q[$];
  logic [15:0] wd [4];
  logic [7:0] key_v [6] = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};
  logic [11:0] key_a [6] = '{12'h01c, 12'h024, 12'h02c, 12'h020, 12'h028,
    12'h030};

  iapc_ctrl #(.UNLOCK_CYC(UNL)) i_iapc_ctrl (
    .core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(),
    .cpu_halt(cpu_halt), .chip_reset_req(chip_reset_req),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en),
    .flash_rdata(flash_rdata));
  iapc_flash_model i_iapc_flash_model (
    .core_clk(core_clk), .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en),
    .flash_rdata(flash_rdata));

  initial forever #10 core_clk = ~core_clk;

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask

  task print_verdict;
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Upper write lanes carry noise: only the low byte is meant to count.
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    r = $urandom;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge core_clk);
    while (!hready) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= {r[31:8], d};
    @(posedge core_clk);
    while (!hready) @(posedge core_clk);
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 8'h00);
  endtask

  task unlock(input logic [7:0] k);
    wr(12'h000, 8'h68);
    rd(12'h000, 32'h68);
    for (int i = 0; i < 6; i++)
      wr(key_a[i], key_v[i] ^ k);
    repeat (UNL + 4) @(posedge core_clk);
  endtask

  // Halt is sampled on the falling edge, clear of the design's updates.
  task run_op(input logic [7:0] c, input int lo);
    int h;
    int n;
    h = 0;
    n = 0;
    wr(12'h000, c);
    while (n < 2300 && !(h > 0 && !cpu_halt)) begin
      @(negedge core_clk);
      if (cpu_halt)
        h++;
      n++;
    end
    @(posedge core_clk);
    chk("halt cycles", 32'(h >= lo), 32'h1);
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rd_ph)
      chk("hrdata", hrdata, exp_q.pop_front());
    rd_ph <= hsel && htrans[1] && !hwrite;
    if (cyc == 8000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] k;
    void'($urandom(26));
    k = 8'h01 + 8'($urandom % 255);
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    for (int a = 0; a <= 32'h40; a += 4)
      rd(a[11:0], 32'h0);
    wr(12'h000, 8'h80);
    rd(12'h000, 32'h0);
    unlock(k);
    rd(12'h000, 32'h60);
    // Correct keys with the window closed must not open it.
    for (int i = 0; i < 6; i++)
      wr(key_a[i], key_v[i]);
    rd(12'h000, 32'h60);
    unlock(8'h00);
    rd(12'h000, 32'he0);
    wr(12'h000, 8'h90);
    wr(12'h00c, 8'h20);
    repeat (34) wr(12'h018, 8'h00);
    rd(12'h00c, 32'h3f);
    run_op(8'h94, 2080);
    rd(12'h000, 32'h90);
    for (int a = 32; a <= 64; a++)
      chk("flash", i_iapc_flash_model.mem[a], a < 64 ? 0 : 32'ha5e5);
    wr(12'h000, 8'h80);
    // A stray word in slot 4 must be gone once the buffer is cleared.
    wr(12'h00c, 8'h24);
    wr(12'h018, 8'h5a);
    wr(12'h008, 8'h01);
    repeat (2) @(posedge core_clk);
    rd(12'h008, 32'h0);
    wr(12'h00c, 8'h20);
    for (int i = 0; i < 4; i++) begin
      wd[i] = 16'($urandom);
      wr(12'h014, wd[i][7:0]);
      wr(12'h018, wd[i][15:8]);
    end
    run_op(8'h84, 2080);
    rd(12'h000, 32'h80);
    for (int i = 0; i < 5; i++)
      chk("flash", i_iapc_flash_model.mem[32+i], i < 4 ? wd[i] : 0);
    wr(12'h000, 8'hb2);
    wr(12'h00c, 8'h22);
    run_op(8'hb3, 3);
    rd(12'h014, wd[2][7:0]);
    rd(12'h018, wd[2][15:8]);
    rd(12'h000, 32'hb2);
    wr(12'h000, 8'hb0);
    wr(12'h00c, 8'h23);
    wr(12'h000, 8'hb1);
    // The refused read bit only drops one cycle after it was written.
    repeat (2) @(posedge core_clk);
    rd(12'h000, 32'hb0);
    rd(12'h014, wd[2][7:0]);
    rd(12'h018, wd[2][15:8]);
    wr(12'h000, 8'h87);
    rd(12'h000, 32'h80);
    wr(12'h000, 8'h10);
    rd(12'h000, 32'h10);
    wr(12'h00c, 8'h40);
    wr(12'h018, 8'h00);
    wr(12'h000, 8'h14);
    repeat (70) @(posedge core_clk);
    rd(12'h000, 32'h10);
    chk("flash", i_iapc_flash_model.mem[64], 32'ha5e5);
    wr(12'h004, 8'h55);
    for (int i = 0; i < 4 && !chip_reset_req; i++)
      @(negedge core_clk);
    chk("chip_reset_req", chip_reset_req, 32'h1);
    // Act on the chip reset request and check the block comes back clean.
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(12'h000, 32'h0);
    rd(12'h004, 32'h0);
    print_verdict();
  end
endmodule
